// [verilog/scm_sync_monitor.sv]
// Sync reference capture, window monitor and serial register port.
`timescale 1ns/1ps
`include "scm_consts.svh"

module scm_sync_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [5:0] generalPinZeroTaps,
  input wire logic spiSenn,
  input wire logic spiSclk,
  input wire logic spiSdi,
  output logic spiSdo,
  output scm_pkg::scm_sync_events_t syncEvents,
  output logic ddcModeOn,
  output logic [13:0] rampValue,
  output logic [7:0] nyquistZone,
  output logic [7:0] inputFreqRange,
  output logic [7:0] syncWindowStatus
);

  ////////////////////////////////////////////////////////////////////////////
  // State and derived signals.

  scm_pkg::scm_state_t st_ff;
  scm_pkg::scm_state_t nxt_st;
  logic [4:0] tapXor;
  logic [4:0] tapRise;
  logic winRise;
  logic syncRouted;
  logic refNow;
  logic refRise;
  logic sclkRise;
  logic sclkFall;
  logic [14:0] frameAddr;
  logic frameRead;
  logic wrIsRead;
  logic [14:0] wrAddr;
  logic [7:0] statusByte;

  ////////////////////////////////////////////////////////////////////////////
  // Window monitor taps.

  // lag flags
  // Adjacent taps disagree where the reference changed between their sampling instants.
  genvar gi;
  generate
    for (gi = 0; gi < `SCM_NUM_TAPS - 1; gi = gi + 1) begin : g_win
      assign tapXor[gi] = generalPinZeroTaps[gi + 1] ^ generalPinZeroTaps[gi];
      assign tapRise[gi] = generalPinZeroTaps[gi + 1] & ~generalPinZeroTaps[gi];
    end
  endgenerate

  // The pin is unrouted after reset, so stray pin activity restarts nothing until software opts in.
  // pin routing
  assign syncRouted = (st_ff.pinCfg == `SCM_PIN_SYNC_IN);
  assign refNow = syncRouted & generalPinZeroTaps[`SCM_TAP_SAMPLE];
  assign refRise = refNow & ~st_ff.refPrev;
  // A rising edge behind the capture tap reaches capture one cycle later, so the flags are
  // taken in the cycle in which the edge crosses the taps, not in the capture cycle.
  assign winRise = syncRouted & ((|tapRise) | (generalPinZeroTaps[0] & ~st_ff.refTopPrev));

  assign sclkRise = spiSclk & ~st_ff.sclkPrev;
  assign sclkFall = ~spiSclk & st_ff.sclkPrev;
  assign frameAddr = st_ff.shiftIn[14:0];
  assign frameRead = st_ff.shiftIn[15];
  // After 23 rises the read flag sits at bit 22 with the address below it.
  assign wrIsRead = st_ff.shiftIn[22];
  assign wrAddr = st_ff.shiftIn[21:7];

  assign statusByte = {1'b0, st_ff.syncEdgeSeen, |st_ff.winFlags, st_ff.winFlags};

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux.

  function automatic logic [7:0] readReg(input logic [14:0] addr);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      `SCM_ADDR_WIN_STATUS: val = statusByte;
      `SCM_ADDR_PIN_CFG: val = st_ff.pinCfg;
      `SCM_ADDR_SYNC_MASK: val = st_ff.syncMask;
      `SCM_ADDR_DECIM: val = st_ff.decimCfg;
      `SCM_ADDR_NYQ_ZONE: val = st_ff.nyqZone;
      `SCM_ADDR_FREQ_RANGE: val = st_ff.freqRange;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      // Event pulses last one enabled cycle; with the enable low they hold like all other state.
      nxt_st.evt = '0;
      nxt_st.sclkPrev = spiSclk;

      // Serial port: 24-bit frame, read flag, 15-bit address, 8 data bits, MSB first.
      if (spiSenn) begin
        nxt_st.spiState = scm_pkg::SP_IDLE;
        nxt_st.bitCnt = 5'd0;
        nxt_st.sdo = 1'b0;
      end else begin
        unique case (st_ff.spiState)
          scm_pkg::SP_IDLE: begin
            nxt_st.spiState = scm_pkg::SP_ADDR;
            nxt_st.bitCnt = 5'd0;
          end
          scm_pkg::SP_ADDR: begin
            if (sclkRise) begin
              nxt_st.shiftIn = {st_ff.shiftIn[22:0], spiSdi};
              nxt_st.bitCnt = st_ff.bitCnt + 5'd1;
            end else if (st_ff.bitCnt == `SCM_ADDR_DONE) begin
              // Read data is latched once the address is complete, so a status read shows that instant.
              nxt_st.spiState = scm_pkg::SP_DATA;
              nxt_st.rdShift = frameRead ? readReg(frameAddr) : 8'h00;
            end
          end
          scm_pkg::SP_DATA: begin
            if (sclkFall && st_ff.bitCnt < `SCM_FRAME_BITS) begin
              nxt_st.sdo = st_ff.rdShift[7];
              nxt_st.rdShift = {st_ff.rdShift[6:0], 1'b0};
            end
            if (sclkRise && st_ff.bitCnt < `SCM_FRAME_BITS) begin
              nxt_st.shiftIn = {st_ff.shiftIn[22:0], spiSdi};
              nxt_st.bitCnt = st_ff.bitCnt + 5'd1;
              if (st_ff.bitCnt == `SCM_FRAME_BITS - 5'd1 && !wrIsRead) begin
                unique case (wrAddr)
                  `SCM_ADDR_WIN_STATUS: begin
                    if (spiSdi && `SCM_BIT_EDGE == 0) begin
                      nxt_st.syncEdgeSeen = 1'b0;
                    end else if (st_ff.shiftIn[`SCM_BIT_EDGE - 1]) begin
                      nxt_st.syncEdgeSeen = 1'b0;
                    end
                  end
                  `SCM_ADDR_PIN_CFG: nxt_st.pinCfg = {st_ff.shiftIn[6:0], spiSdi};
                  `SCM_ADDR_SYNC_MASK: nxt_st.syncMask = {st_ff.shiftIn[6:0], spiSdi};
                  `SCM_ADDR_DECIM: nxt_st.decimCfg = {st_ff.shiftIn[6:0], spiSdi};
                  `SCM_ADDR_NYQ_ZONE: nxt_st.nyqZone = {st_ff.shiftIn[6:0], spiSdi};
                  `SCM_ADDR_FREQ_RANGE: nxt_st.freqRange = {st_ff.shiftIn[6:0], spiSdi};
                  default: ;
                endcase
              end
            end
          end
          default: nxt_st.spiState = scm_pkg::SP_IDLE;
        endcase
      end

      // Capture runs after the port so a new edge beats a clear in the same cycle.
      nxt_st.refPrev = refNow;
      // The top tap of the last cycle tells an edge between cycles from a level already high.
      nxt_st.refTopPrev = syncRouted & generalPinZeroTaps[`SCM_NUM_TAPS - 1];
      nxt_st.rampCnt = st_ff.rampCnt + 14'h0001;
      // A falling reference leaves the flags as they were.
      if (winRise) begin
        nxt_st.winFlags = tapXor;
      end
      if (refRise) begin
        nxt_st.syncEdgeSeen = 1'b1;
        if (st_ff.decimCfg[3:0] == 4'h0) begin
          nxt_st.evt.rampRestart = 1'b1;
          nxt_st.rampCnt = 14'h0000;
        end else begin
          nxt_st.evt.dividerReset = st_ff.syncMask[`SCM_MASK_BIT_DIV];
          nxt_st.evt.oscPhaseReset = st_ff.syncMask[`SCM_MASK_BIT_NCO];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.pinCfg <= `SCM_RST_PIN_CFG;
      st_ff.syncMask <= `SCM_RST_SYNC_MASK;
      st_ff.decimCfg <= `SCM_RST_DECIM;
      st_ff.nyqZone <= `SCM_RST_NYQ_ZONE;
      st_ff.freqRange <= `SCM_RST_FREQ_RANGE;
      st_ff.spiState <= scm_pkg::SP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign spiSdo = st_ff.sdo;
  assign syncEvents = st_ff.evt;
  assign ddcModeOn = (st_ff.decimCfg[3:0] != 4'h0);
  assign rampValue = st_ff.rampCnt;
  assign nyquistZone = st_ff.nyqZone;
  assign inputFreqRange = st_ff.freqRange;
  assign syncWindowStatus = statusByte;

endmodule // scm_sync_monitor

// [verilog/scm_consts.svh]
// Constants of the sync reference capture and window monitor.
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

`define SCM_ADDR_WIN_STATUS 15'h0140
`define SCM_ADDR_PIN_CFG 15'h0146
`define SCM_ADDR_SYNC_MASK 15'h0150
`define SCM_ADDR_DECIM 15'h0169
`define SCM_ADDR_NYQ_ZONE 15'h016B
`define SCM_ADDR_FREQ_RANGE 15'h0132

`define SCM_PIN_SYNC_IN 8'h00
`define SCM_RST_PIN_CFG 8'hFF
`define SCM_RST_SYNC_MASK 8'h03
`define SCM_RST_DECIM 8'h00
`define SCM_RST_NYQ_ZONE 8'h00
`define SCM_RST_FREQ_RANGE 8'h00

`define SCM_BIT_EDGE 6
`define SCM_BIT_COMBINED 5
`define SCM_MASK_BIT_DIV 0
`define SCM_MASK_BIT_NCO 1

// Tap k of the capture delay line sits at -60ps + 40ps * k from the clock rise.
`define SCM_TAP_FIRST_PS -60
`define SCM_TAP_STEP_PS 40
`define SCM_SAMPLE_DELAY_PS 60
`define SCM_TAP_SAMPLE 3
`define SCM_NUM_TAPS 6

`define SCM_FRAME_BITS 5'd24
`define SCM_ADDR_DONE 5'd16

`endif

// [verilog/scm_pkg.sv]
// Types shared by the sync reference capture and window monitor.
package scm_pkg;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ADDR = 2'b01,
    SP_DATA = 2'b11
  } scm_spi_state_t;

  typedef struct packed {
    logic rampRestart;
    logic dividerReset;
    logic oscPhaseReset;
  } scm_sync_events_t;

  typedef struct packed {
    logic [7:0] pinCfg;
    logic [7:0] syncMask;
    logic [7:0] decimCfg;
    logic [7:0] nyqZone;
    logic [7:0] freqRange;
    logic [4:0] winFlags;
    logic syncEdgeSeen;
    logic refPrev;
    logic refTopPrev;
    logic [13:0] rampCnt;
    scm_sync_events_t evt;
    scm_spi_state_t spiState;
    logic sclkPrev;
    logic [4:0] bitCnt;
    logic [23:0] shiftIn;
    logic [7:0] rdShift;
    logic sdo;
  } scm_state_t;

endpackage

// [verif/scm_sync_checker.sv]
// Port assertions for the sync monitor.
`timescale 1ns/1ps
module scm_sync_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [5:0] generalPinZeroTaps,
  input wire logic spiSenn,
  input wire logic spiSdo,
  input wire scm_pkg::scm_sync_events_t syncEvents,
  input wire logic ddcModeOn,
  input wire logic [13:0] rampValue,
  input wire logic [7:0] syncWindowStatus
);
  wire logic [5:0] tp = generalPinZeroTaps;
  wire logic [7:0] st = syncWindowStatus;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_bit7_zero: assert property (!st[7]) else $error("status bit 7 set");
  chk_flags_taps: assert property ($changed(st[4:0]) |->
    st[4:0] == ($past(tp[5:1]) ^ $past(tp[4:0]))) else $error("window flags wrong");
  chk_event_edge: assert property (|syncEvents |-> st[6]) else $error("event without edge bit");
  chk_or_flag: assert property (st[5] == |st[4:0]) else $error("combined flag wrong");
  chk_edge_rise: assert property ($rose(st[6]) |->
    $past(tp[3]) && !$past(tp[3], 2)) else $error("edge bit without edge");
  chk_edge_clear: assert property ($fell(st[6]) |-> !$past(spiSenn)) else $error("edge bit lost");
  chk_ramp_zero: assert property (syncEvents.rampRestart |->
    ##[0:1] rampValue == 14'h0) else $error("ramp not restarted");
  chk_ddc_mode: assert property (syncEvents.dividerReset || syncEvents.oscPhaseReset |->
    ddcModeOn && !syncEvents.rampRestart) else $error("decimation reset in bypass");
  // Restart cycles are left out because the ramp clears on the same edge that raises rampRestart.
  chk_ramp_count: assert property ($past(resetn) && $past(ce) && !syncEvents.rampRestart &&
    !$past(syncEvents.rampRestart) |-> rampValue == 14'($past(rampValue) + 14'h1)) else $error("ramp step");
  chk_ce_freeze: assert property ($past(resetn) && !$past(ce) |->
    $stable(rampValue) && $stable(st)) else $error("state moved with clock enable low");
  chk_sdo_idle: assert property (spiSenn && $past(spiSenn) |-> !spiSdo) else $error("read line busy");
  cover property (syncEvents.rampRestart);
  cover property (syncEvents.oscPhaseReset);
  cover property ($fell(st[6]));
endmodule // scm_sync_checker
bind scm_sync_monitor scm_sync_checker u_chk (.clock(clock), .resetn(resetn), .ce(ce),
  .generalPinZeroTaps(generalPinZeroTaps), .spiSenn(spiSenn), .spiSdo(spiSdo), .syncEvents(syncEvents),
  .ddcModeOn(ddcModeOn), .rampValue(rampValue), .syncWindowStatus(syncWindowStatus));

// [verif/scm_sync_source.sv]
// Reference source model driving the delayed pin samples.
`timescale 1ns/1ps
module scm_sync_source (
  input wire logic clock,
  input wire logic fire,
  input wire logic [2:0] pos,
  output logic [5:0] taps
);
  logic [1:0] hold = 2'h0;
  initial taps = 6'h00;
  always @(posedge clock) begin
    if (fire) begin
      taps <= 6'h3F << pos;
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      taps <= 6'h3F;
      hold <= hold - 2'h1;
    end else begin
      taps <= 6'h00;
    end
  end
endmodule // scm_sync_source

// [verif/tb_scm_sync_monitor.sv]
// Self-checking bench for the sync monitor.
`timescale 1ns/1ps
module tb_scm_sync_monitor;
  logic clock = 0, resetn = 0, ce = 1, spiSenn = 1, spiSclk = 0, spiSdi = 0, fire = 0, spiSdo, ddcModeOn;
  logic [2:0] pos = 3'h0;
  logic [5:0] taps;
  scm_pkg::scm_sync_events_t syncEvents;
  logic [13:0] rampValue;
  logic [7:0] nyquistZone, inputFreqRange, syncWindowStatus, rd;
  int fail_count = 0, num_checks = 0, cycles = 0, nRamp = 0, nDiv = 0, nOsc = 0;
  initial forever #50 clock = ~clock;
  scm_sync_monitor u_dut (.clock(clock), .resetn(resetn), .ce(ce), .generalPinZeroTaps(taps),
    .spiSenn(spiSenn), .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .syncEvents(syncEvents),
    .ddcModeOn(ddcModeOn), .rampValue(rampValue), .nyquistZone(nyquistZone),
    .inputFreqRange(inputFreqRange), .syncWindowStatus(syncWindowStatus));
  scm_sync_source u_src (.clock(clock), .fire(fire), .pos(pos), .taps(taps));
  always @(posedge clock) begin
    cycles++;
    nRamp += syncEvents.rampRestart;
    nDiv += syncEvents.dividerReset;
    nOsc += syncEvents.oscPhaseReset;
    if (cycles == 6000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(logic [7:0] got, logic [7:0] e);
    num_checks++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // Each serial clock level lasts two cycles, so read data is settled before every fall.
  task automatic spi(logic rw, logic [14:0] a, logic [7:0] d);
    logic [23:0] fr;
    fr = {rw, a, d};
    spiSenn = 0;
    for (int i = 23; i >= 0; i--) begin
      spiSdi = fr[i];
      tick(2);
      spiSclk = 1;
      tick(2);
      if (i < 8) rd[i] = spiSdo;
      spiSclk = 0;
    end
    tick(3);
    spiSenn = 1;
    tick(2);
  endtask
  task automatic edge_at(logic [2:0] p);
    pos = p;
    fire = 1;
    tick();
    fire = 0;
    tick(6);
  endtask
  task automatic t_reset();
    check(syncWindowStatus, 8'h00);
    check(nyquistZone, 8'h00);
    check(inputFreqRange, 8'h00);
    check(8'(ddcModeOn), 8'h00);
    edge_at(3'h3);
    check(syncWindowStatus, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_windows();
    spi(0, 15'h0146, 8'h00);
    for (int p = 0; p < 6; p++) begin
      edge_at(3'(p));
      check(syncWindowStatus, p == 0 ? 8'h40 : 8'h60 | (8'h01 << (p - 1)));
      check(8'(rampValue), p < 4 ? 8'h05 : 8'h04);
    end
    check(8'(nRamp), 8'h06);
    $display("test windows done");
  endtask
  task automatic t_clear();
    spi(0, 15'h0140, 8'h3F);
    spi(1, 15'h0140, 8'h00);
    check(rd, 8'h70);
    spi(0, 15'h0140, 8'h40);
    check(syncWindowStatus, 8'h30);
    spi(0, 15'h0200, 8'hFF);
    spi(1, 15'h0200, 8'h00);
    check(rd, 8'h00);
    $display("test clear done");
  endtask
  task automatic t_modes();
    spi(0, 15'h0169, 8'h01);
    check(8'(ddcModeOn), 8'h01);
    spi(0, 15'h0150, 8'h02);
    edge_at(3'h2);
    check(8'(nOsc), 8'h01);
    check(8'(nDiv), 8'h00);
    spi(0, 15'h0150, 8'h01);
    edge_at(3'h2);
    check(8'(nDiv), 8'h01);
    check(8'(nRamp), 8'h06);
    check(syncWindowStatus, 8'h62);
    ce = 0;
    edge_at(3'h1);
    ce = 1;
    check(syncWindowStatus, 8'h62);
    spi(0, 15'h016B, 8'h01);
    spi(0, 15'h0132, 8'h02);
    check(nyquistZone, 8'h01);
    check(inputFreqRange, 8'h02);
    $display("test modes done");
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    resetn = 1;
    tick();
    t_reset();
    t_windows();
    t_clear();
    t_modes();
    give_verdict();
  end
endmodule // tb_scm_sync_monitor
